/* port6_low_pins.sv */
// How it works
// - Timer-out-A enable makes pin 1 drive timer output A; else direction bit rules.
// - Pin 0 level feeds key-sense input 0, and the timer external clock input only when pin 0 is an input and the external clock is selected.
// - Every port bit has its own pull-up control bit.
// - Pull-up on only when control bit is 1 and direction bit is 0.
// - Reset and hardware standby clear the pull-up control register to zero.
// - Software standby leaves pull-up control bits and pull-up states unchanged.
// - All pull-ups forced off during reset or hardware standby.
// - Port read gives latch for output bits, live pin level for input bits.
// - Pull-up control is 8-bit read/write, kept in software standby, resets zero.
module port6_low_pins (
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic hw_standby, // Hardware standby in effect
    input wire logic sw_standby, // Software standby in effect
    input wire logic [7:0] pin_in, // Pin levels
    output logic [7:0] pin_out, // Pin drive values
    output logic [7:0] pin_oe_n, // Pin drive enable, low drives
    output logic [7:0] pullup_en, // Input pull-up on
    input wire logic timer_output_a, // Compare output A of the timer
    output logic timer_ext_clock_in, // External clock to the timer
    output logic timer_capture_in_a, // Capture input A to the timer
    output logic timer_capture_in_b, // Capture input B to the timer
    output logic [7:0] key_sense_input // Key-sense inputs
);

    // ********************************************************
    // Register bank
    // ********************************************************
    port6_low_pkg::regs_t regs_r, regs_nxt;
    port6_low_pkg::wr_state_t wr_r, wr_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wlane_r, wlane_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [7:0] port_read;
    logic do_write;
    logic write_hit;

    // Input bits read the live pin, output bits the latch, timer pins included
    assign port_read = (regs_r.pin_direction_bits & regs_r.pin_output_latch)
                     | (~regs_r.pin_direction_bits & pin_in);

    assign s_axi_awready = (wr_r == port6_low_pkg::wr_idle)
                        || (wr_r == port6_low_pkg::wr_have_data);
    assign s_axi_wready = (wr_r == port6_low_pkg::wr_idle)
                       || (wr_r == port6_low_pkg::wr_have_addr);
    assign s_axi_bvalid = (wr_r == port6_low_pkg::wr_resp);
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        logic [7:0] a;
        logic [7:0] d;
        logic lane;
        a = awaddr_r;
        d = wdata_r;
        lane = wlane_r;
        wr_nxt = wr_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wlane_nxt = wlane_r;
        bresp_nxt = bresp_r;
        do_write = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            a = s_axi_awaddr;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d = s_axi_wdata[7:0];
            lane = s_axi_wstrb[0];
            wdata_nxt = s_axi_wdata[7:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        case (wr_r)
            port6_low_pkg::wr_idle: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    do_write = 1'b1;
                end else if (s_axi_awvalid) begin
                    wr_nxt = port6_low_pkg::wr_have_addr;
                end else if (s_axi_wvalid) begin
                    wr_nxt = port6_low_pkg::wr_have_data;
                end
            end
            port6_low_pkg::wr_have_addr: begin
                do_write = s_axi_wvalid;
            end
            port6_low_pkg::wr_have_data: begin
                do_write = s_axi_awvalid;
            end
            default: begin
                if (s_axi_bready) begin
                    wr_nxt = port6_low_pkg::wr_idle;
                end
            end
        endcase
        write_hit = (a == port6_low_pkg::dir_offset) || (a == port6_low_pkg::latch_offset)
                 || (a == port6_low_pkg::pullup_offset) || (a == port6_low_pkg::out_ctrl_offset)
                 || (a == port6_low_pkg::clk_ctrl_offset);
        regs_nxt = regs_r;
        if (do_write) begin
            wr_nxt = port6_low_pkg::wr_resp;
            bresp_nxt = write_hit ? port6_low_pkg::resp_okay : port6_low_pkg::resp_slverr;
            // Only byte lane 0 carries register bits; other lanes are ignored
            if (lane) begin
                if (a == port6_low_pkg::dir_offset) begin
                    regs_nxt.pin_direction_bits = d;
                end else if (a == port6_low_pkg::latch_offset) begin
                    regs_nxt.pin_output_latch = d;
                end else if (a == port6_low_pkg::pullup_offset) begin
                    regs_nxt.pullup_control_bits = d;
                end else if (a == port6_low_pkg::out_ctrl_offset) begin
                    regs_nxt.timer_out_a_enable = d[port6_low_pkg::out_a_enable_bit];
                end else if (a == port6_low_pkg::clk_ctrl_offset) begin
                    regs_nxt.timer_clock_select = d[port6_low_pkg::cks_lsb +: 2];
                end
            end
        end
        // Software standby has no branch here: every bit simply holds
        if (hw_standby) begin
            regs_nxt = port6_low_pkg::regs_reset;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = port6_low_pkg::resp_okay;
            if (s_axi_araddr == port6_low_pkg::dir_offset) begin
                rdata_nxt[7:0] = regs_r.pin_direction_bits;
            end else if (s_axi_araddr == port6_low_pkg::latch_offset) begin
                rdata_nxt[7:0] = port_read;
            end else if (s_axi_araddr == port6_low_pkg::pullup_offset) begin
                rdata_nxt[7:0] = regs_r.pullup_control_bits;
            end else if (s_axi_araddr == port6_low_pkg::out_ctrl_offset) begin
                rdata_nxt[port6_low_pkg::out_a_enable_bit] = regs_r.timer_out_a_enable;
            end else if (s_axi_araddr == port6_low_pkg::clk_ctrl_offset) begin
                rdata_nxt[port6_low_pkg::cks_lsb +: 2] = regs_r.timer_clock_select;
            end else begin
                rresp_nxt = port6_low_pkg::resp_slverr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_r <= port6_low_pkg::regs_reset;
            wr_r <= port6_low_pkg::wr_idle;
            awaddr_r <= 8'h00;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            bresp_r <= port6_low_pkg::resp_okay;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= port6_low_pkg::resp_okay;
        end else begin
            regs_r <= regs_nxt;
            wr_r <= wr_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wlane_r <= wlane_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ********************************************************
    // Pin multiplexing and pull-ups
    // ********************************************************
    // Gated combinationally so the pull-ups drop in the same cycle reset arrives
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_out[i] = regs_r.pin_output_latch[i];
            pin_oe_n[i] = !regs_r.pin_direction_bits[i];
            pullup_en[i] = regs_r.pullup_control_bits[i] && !regs_r.pin_direction_bits[i]
                        && aresetn && !hw_standby;
        end
        if (regs_r.timer_out_a_enable) begin
            pin_out[port6_low_pkg::timer_out_pin] = timer_output_a;
            pin_oe_n[port6_low_pkg::timer_out_pin] = 1'b0;
            // Pull-up keeps following its control and direction bits on the timer pin
        end
    end

    // Key-sense and capture paths always watch the pin, even while driven; the external clock only while pin 0 is an input and cks_external is selected
    assign key_sense_input = pin_in;
    assign timer_capture_in_a = pin_in[port6_low_pkg::capture_a_pin];
    assign timer_capture_in_b = pin_in[port6_low_pkg::capture_b_pin];
    assign timer_ext_clock_in = pin_in[port6_low_pkg::ext_clock_pin]
        && !regs_r.pin_direction_bits[port6_low_pkg::ext_clock_pin]
        && (regs_r.timer_clock_select == port6_low_pkg::cks_external);

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_timer_out_drive: assert property (
        regs_r.timer_out_a_enable |-> !pin_oe_n[1] && pin_out[1] == timer_output_a)
        else $error("pin 1 not driving timer output A");
    chk_ext_clock_gate: assert property (
        (regs_r.timer_clock_select != port6_low_pkg::cks_external) |-> !timer_ext_clock_in)
        else $error("external clock passed while not selected");
    chk_ext_clock_pin: assert property (
        (regs_r.timer_clock_select == port6_low_pkg::cks_external
         && !regs_r.pin_direction_bits[0]) |-> timer_ext_clock_in == pin_in[0])
        else $error("external clock does not follow pin 0");
    chk_pullup_rule: assert property (
        !hw_standby |-> pullup_en == (regs_r.pullup_control_bits
                                      & ~regs_r.pin_direction_bits))
        else $error("pull-up state wrong");
    chk_hwstby_clears: assert property (
        hw_standby |=> regs_r.pullup_control_bits == 8'h00)
        else $error("hardware standby did not clear pull-up control");
    chk_hwstby_forces: assert property (
        hw_standby |-> pullup_en == 8'h00)
        else $error("pull-up on during hardware standby");
    chk_swstby_holds: assert property (
        (sw_standby && !hw_standby && !do_write) |=> $stable(regs_r.pullup_control_bits))
        else $error("pull-up control changed in software standby");
    chk_pullup_write: assert property (
        (do_write && wlane_nxt && awaddr_nxt == port6_low_pkg::pullup_offset && !hw_standby)
        |=> regs_r.pullup_control_bits == $past(wdata_nxt))
        else $error("pull-up control write lost");
    chk_read_port: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == port6_low_pkg::latch_offset)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(port_read))
        else $error("port read value wrong");
    chk_plain_output: assert property (
        (regs_r.pin_direction_bits[0] |-> !pin_oe_n[0] && pin_out[0] == regs_r.pin_output_latch[0]))
        else $error("plain output does not drive latch");
    chk_write_resp: assert property (
        do_write |=> s_axi_bvalid)
        else $error("write response missing");

    cov_timer_out: cover property (regs_r.timer_out_a_enable && pin_oe_n[1] == 1'b0);
    cov_pullup_on: cover property (pullup_en != 8'h00);
    cov_hwstby: cover property ((pullup_en != 8'h00) ##1 hw_standby);
    cov_ext_clock: cover property (timer_ext_clock_in);

endmodule

/* port6_low_pkg.sv */
package port6_low_pkg;

    // ********************************************************
    // Register map (byte addresses, one aligned word each)
    // ********************************************************
    localparam logic [7:0] dir_offset = 8'h00;
    localparam logic [7:0] latch_offset = 8'h04;
    localparam logic [7:0] pullup_offset = 8'h08;
    localparam logic [7:0] out_ctrl_offset = 8'h0C;
    localparam logic [7:0] clk_ctrl_offset = 8'h10;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int out_a_enable_bit = 0;
    localparam int cks_lsb = 0;
    localparam int timer_out_pin = 1;
    localparam int ext_clock_pin = 0;
    localparam int capture_a_pin = 2;
    localparam int capture_b_pin = 3;
    localparam logic [7:0] port_reset = 8'h00;
    localparam logic [1:0] cks_reset = 2'h0;
    // Clock-select code that picks the pin as the external counting clock
    localparam logic [1:0] cks_external = 2'h3;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef struct packed {
        logic [7:0] pin_direction_bits;
        logic [7:0] pin_output_latch;
        logic [7:0] pullup_control_bits;
        logic timer_out_a_enable;
        logic [1:0] timer_clock_select;
    } regs_t;

    localparam regs_t regs_reset = '{port_reset, port_reset, port_reset, 1'b0, cks_reset};

    typedef enum logic [1:0] {
        wr_idle = 2'b00,
        wr_have_addr = 2'b01,
        wr_resp = 2'b11,
        wr_have_data = 2'b10
    } wr_state_t;

endpackage

/* pin_world.sv */
// ****************************************
// External circuitry on the port pins
// ****************************************
module pin_world (
    input wire logic aclk, // Steps the floating-line pattern
    input wire logic [7:0] pin_out, // Device drive value
    input wire logic [7:0] pin_oe_n, // Device drive enable, low drives
    input wire logic [7:0] pullup_en, // Device pull-up on
    input wire logic [7:0] ext_val, // Level driven from outside
    input wire logic [7:0] ext_en, // Outside drive on
    output logic [7:0] pin_in // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A line nobody holds flips every cycle, so a stale value never reads as valid
    logic [7:0] float_r = 8'h00;
    always @(posedge aclk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_r[i];
        end
    end
endmodule

/* port6_low_pins_test.sv */
module port6_low_pins_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] dir, lat, pu;
        logic toe;
        logic [1:0] cks;
        logic tmr;
        logic [7:0] ext, oe, out, pul, rdv;
        logic clk;
    } row_t;
    localparam logic [1:0] ok = port6_low_pkg::resp_okay;
    localparam logic [7:0] a_pu = port6_low_pkg::pullup_offset;
    localparam logic [7:0] a_lat = port6_low_pkg::latch_offset;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic hw_standby = 1'b0, sw_standby = 1'b0, timer_output_a = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic timer_ext_clock_in, timer_capture_in_a, timer_capture_in_b;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, key_sense_input;
    int errors = 0, checks_done = 0, cycles = 0;
    row_t rows [6] = '{
        '{8'hF0, 8'hA5, 8'h0F, 1'b0, 2'h0, 1'b0, 8'h3C, 8'h0F, 8'hA0, 8'h0F, 8'hAC, 1'b0},
        '{8'h00, 8'h00, 8'hFF, 1'b0, 2'h3, 1'b0, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h01, 1'b1},
        '{8'h00, 8'h00, 8'hFF, 1'b1, 2'h3, 1'b1, 8'h00, 8'hFD, 8'h02, 8'hFF, 8'h02, 1'b0},
        '{8'h02, 8'h00, 8'hFF, 1'b1, 2'h3, 1'b1, 8'hFD, 8'hFD, 8'h02, 8'hFD, 8'hFD, 1'b1},
        '{8'h00, 8'h00, 8'h00, 1'b0, 2'h1, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 1'b0},
        '{8'h00, 8'h00, 8'h55, 1'b0, 2'h2, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h55, 8'hFF, 1'b0}};

    port6_low_pins port6_low_pins_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hw_standby, .sw_standby, .pin_in, .pin_out, .pin_oe_n, .pullup_en, .timer_output_a,
        .timer_ext_clock_in, .timer_capture_in_a, .timer_capture_in_b, .key_sense_input);
    pin_world pin_world_inst (.aclk, .pin_out, .pin_oe_n, .pullup_en, .ext_val, .ext_en,
        .pin_in);

    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end

    // ****************************************
    // Comparison, report and bus tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                check(s_axi_bresp, er);
                break;
            end
        end
        // One idle edge so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                check(s_axi_rdata, {24'h0, ed});
                check(s_axi_rresp, er);
                break;
            end
        end
        @(posedge aclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] k;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        check(pullup_en, 8'h00);
        check(pin_oe_n, 8'hFF);
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(a_pu, 8'h00, ok);
        foreach (rows[i]) begin
            wr(port6_low_pkg::dir_offset, rows[i].dir, ok);
            wr(a_lat, rows[i].lat, ok);
            wr(a_pu, rows[i].pu, ok);
            wr(port6_low_pkg::out_ctrl_offset, {7'h0, rows[i].toe}, ok);
            wr(port6_low_pkg::clk_ctrl_offset, {6'h0, rows[i].cks}, ok);
            timer_output_a <= rows[i].tmr;
            ext_val <= rows[i].ext;
            k = rows[i].out | (rows[i].ext & rows[i].oe);
            @(negedge aclk);
            check(pin_oe_n, rows[i].oe);
            check(pin_out & ~pin_oe_n, rows[i].out);
            check(pullup_en, rows[i].pul);
            check(timer_ext_clock_in, rows[i].clk);
            check(key_sense_input, k);
            check({timer_capture_in_b, timer_capture_in_a}, k[3:2]);
            @(posedge aclk);
            rd(a_lat, rows[i].rdv, ok);
            rd(a_pu, rows[i].pu, ok);
        end
        for (int b = 0; b < 8; b++) begin
            wr(a_pu, 8'h01 << b, ok);
            @(negedge aclk);
            check(pullup_en, 8'h01 << b);
            @(posedge aclk);
        end
        // Nothing outside drives now, so only the pull-ups hold the inputs high
        ext_en <= 8'h00;
        wr(a_pu, 8'hFF, ok);
        rd(a_lat, 8'hFF, ok);
        sw_standby <= 1'b1;
        @(negedge aclk);
        check(pullup_en, 8'hFF);
        @(posedge aclk);
        rd(a_pu, 8'hFF, ok);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        @(negedge aclk);
        check(pullup_en, 8'h00);
        @(posedge aclk);
        hw_standby <= 1'b0;
        @(posedge aclk);
        rd(a_pu, 8'h00, ok);
        wr(a_pu, 8'hF0, ok);
        aresetn <= 1'b0;
        @(negedge aclk);
        check(pullup_en, 8'h00);
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(a_pu, 8'h00, ok);
        // Lane 0 strobe low: the write is answered but nothing lands
        s_axi_wstrb <= 4'hE;
        wr(a_pu, 8'hAA, ok);
        rd(a_pu, 8'h00, ok);
        wr(8'h14, 8'hFF, port6_low_pkg::resp_slverr);
        rd(8'h14, 8'h00, port6_low_pkg::resp_slverr);
        end_of_test();
    end
endmodule
